// ==== shared/pq_emc_pkg.sv ====
package pq_emc_pkg;

  // Register addresses, at their printed word offsets.
  localparam int PQ_AW = 12;
  localparam logic [11:0] PQ_ADDR_IRQ_EN = 12'h406;
  localparam logic [11:0] PQ_ADDR_EVT_EN = 12'h407;
  localparam logic [11:0] PQ_ADDR_OC_THR = 12'h409;
  localparam logic [11:0] PQ_ADDR_OC_CAP_A = 12'h40A;
  localparam logic [11:0] PQ_ADDR_OC_CAP_B = 12'h40B;
  localparam logic [11:0] PQ_ADDR_OC_CAP_C = 12'h40C;
  localparam logic [11:0] PQ_ADDR_OC_CAP_N = 12'h40D;
  localparam logic [11:0] PQ_ADDR_VREF = 12'h40F;
  localparam logic [11:0] PQ_ADDR_SAG_THR = 12'h410;
  localparam logic [11:0] PQ_ADDR_SAG_A = 12'h411;
  localparam logic [11:0] PQ_ADDR_SAG_B = 12'h412;
  localparam logic [11:0] PQ_ADDR_SAG_C = 12'h413;
  localparam logic [11:0] PQ_ADDR_SURGE_THR = 12'h414;
  localparam logic [11:0] PQ_ADDR_SURGE_A = 12'h415;
  localparam logic [11:0] PQ_ADDR_SURGE_B = 12'h416;
  localparam logic [11:0] PQ_ADDR_SURGE_C = 12'h417;
  localparam logic [11:0] PQ_ADDR_IDLE_STS = 12'h41F;
  localparam logic [11:0] PQ_ADDR_OC_STS = 12'h48F;
  localparam logic [11:0] PQ_ADDR_IRQ_STS = 12'h4F0;

  // Field widths and positions.
  localparam int PQ_VW = 24;
  localparam int PQ_IRQ_W = 16;
  localparam int PQ_EVT_W = 17;
  localparam int PQ_IDLE_W = 18;
  localparam int PQ_CLASSES = 6;
  localparam int PQ_EVT_READY_BIT = 16;
  localparam int PQ_EVT_IDLE_LSB = 10;
  localparam int PQ_EVT_SIGN_LSB = 6;
  localparam int PQ_EVT_SURGE_LSB = 3;
  localparam int PQ_EVT_SAG_LSB = 0;

  // Values after reset.
  localparam logic [23:0] PQ_RST_OC_THR = 24'hFFFFFF;
  localparam logic [23:0] PQ_RST_OC_CAP = 24'h000000;
  localparam logic [23:0] PQ_RST_VREF = 24'h045D45;
  localparam logic [23:0] PQ_RST_SAG_THR = 24'h000000;
  localparam logic [23:0] PQ_RST_SAG_CAP = 24'h7FFFFF;
  localparam logic [23:0] PQ_RST_SURGE_THR = 24'hFFFFFF;
  localparam logic [23:0] PQ_RST_SURGE_CAP = 24'h000000;
  localparam logic [15:0] PQ_RST_IRQ_EN = 16'h0000;
  localparam logic [16:0] PQ_RST_EVT_EN = 17'h00000;

  // Register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pq_reg_req_t;

  // Zero-crossing pulses; index 0 is phase A. Packed order matches enable bits 15:6.
  typedef struct packed {
    logic [2:0] cur;
    logic comb;
    logic [2:0] volt;
    logic [2:0] tmo;
  } pq_zc_t;

endpackage : pq_emc_pkg

// ==== core/pq_emc_top.sv ====
`timescale 1ns/10ps

// Notes on behaviour
// RULE_01 - Current zero-crossing interrupts gated by bits 15:13.
// RULE_02 - Combined voltage zero-crossing interrupt gated by bit 12.
// RULE_03 - Voltage zero-crossing interrupts gated by bits 11:9.
// RULE_04 - Zero-crossing timeout interrupts gated by bits 8:6.
// RULE_05 - Bits 5:0 gate idle enter/exit interrupts.
// RULE_06 - Event bit 16: event low on sample ready.
// RULE_07 - Event bits 15:10: low when class idle.
// RULE_08 - Event bits 9:6: low on negative last pulse.
// RULE_09 - Event bits 5:3 surge, 2:0 sag.
// RULE_10 - Writable 24-bit overcurrent threshold, resets all ones.
// RULE_11 - Capture enabled phase current above threshold.
// RULE_12 - Writable voltage reference, resets 0x45D45.
// RULE_13 - Writable sag threshold, resets to zero.
// RULE_14 - Per-phase sag rms capture, resets 0x7FFFFF.
// RULE_15 - Writable surge threshold, resets all ones.
// RULE_16 - Per-phase surge rms capture, resets zero.
// RULE_17 - Per-phase idle status bits, six per phase.
// RULE_18 - Surge and sag status follow live condition.
// RULE_19 - Overcurrent only on enabled current channels.
// RULE_20 - Four overcurrent phase flags, A B C N.
// RULE_21 - Interrupt on enabled pending flag; event likewise.
// RULE_22 - Reserved bits read zero, ignore writes.
module pq_emc_top
  import pq_emc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register access port.
  input wire pq_reg_req_t i_reg,
  output logic [31:0] o_rd_data,
  output logic o_rd_valid,
  // Zero-crossing and idle detectors.
  input wire pq_zc_t i_zc,
  input wire logic [PQ_IDLE_W-1:0] i_idle,
  // Waveform and energy pulse outputs.
  input wire logic i_sample_ready,
  input wire logic [3:0] i_pulse_out,
  input wire logic [3:0] i_pulse_neg,
  // Half-cycle rms results; index 0 is phase A, index 3 neutral.
  input wire logic [3:0][PQ_VW-1:0] i_irms,
  input wire logic i_irms_upd,
  input wire logic [2:0][PQ_VW-1:0] i_vrms,
  input wire logic i_vrms_upd,
  input wire logic [3:0] i_overcurrent_enable,
  // Pins and status to the rest of the device.
  output logic o_irq_n,
  output logic o_event_n,
  output logic [3:0] o_overcurrent_phase_flags,
  output logic [2:0] o_surge_state,
  output logic [2:0] o_sag_state,
  output logic [PQ_VW-1:0] o_voltage_ref_value
);

  logic [PQ_IRQ_W-1:0] irq_en_q;
  logic [PQ_IRQ_W-1:0] irq_sts_q;
  logic [PQ_IRQ_W-1:0] irq_sts_d;
  logic [PQ_EVT_W-1:0] evt_en_q;
  logic [PQ_VW-1:0] oc_thr_q;
  logic [PQ_VW-1:0] sag_thr_q;
  logic [PQ_VW-1:0] surge_thr_q;
  logic [3:0][PQ_VW-1:0] oc_cap_q;
  logic [2:0][PQ_VW-1:0] sag_cap_q;
  logic [2:0][PQ_VW-1:0] surge_cap_q;
  logic [PQ_IDLE_W-1:0] idle_q;
  logic [3:0] pulse_q;
  logic [3:0] neg_q;
  logic ready_q;
  logic [3:0] oc_flag_q;
  logic [2:0] sag_q;
  logic [2:0] surge_q;

  // Write decode.
  wire wr_irq_en = i_reg.wr && (i_reg.addr == PQ_ADDR_IRQ_EN);
  wire wr_evt_en = i_reg.wr && (i_reg.addr == PQ_ADDR_EVT_EN);
  wire wr_oc_thr = i_reg.wr && (i_reg.addr == PQ_ADDR_OC_THR);
  wire wr_vref = i_reg.wr && (i_reg.addr == PQ_ADDR_VREF);
  wire wr_sag_thr = i_reg.wr && (i_reg.addr == PQ_ADDR_SAG_THR);
  wire wr_surge_thr = i_reg.wr && (i_reg.addr == PQ_ADDR_SURGE_THR);
  wire wr_irq_sts = i_reg.wr && (i_reg.addr == PQ_ADDR_IRQ_STS);

  // Per-class idle summaries: any phase idle, and any phase changing state.
  logic [PQ_CLASSES-1:0] class_idle;
  logic [PQ_CLASSES-1:0] class_change;
  genvar k;
  generate
    for (k = 0; k < PQ_CLASSES; k++) begin : g_class
      assign class_idle[k] = i_idle[k] | i_idle[PQ_CLASSES+k] | i_idle[2*PQ_CLASSES+k]; // [RULE_07]
      assign class_change[k] = (i_idle[k] ^ idle_q[k])
          | (i_idle[PQ_CLASSES+k] ^ idle_q[PQ_CLASSES+k])
          | (i_idle[2*PQ_CLASSES+k] ^ idle_q[2*PQ_CLASSES+k]); // [RULE_05]
    end
  endgenerate

  // Sticky interrupt status; a new event wins over a clear in the same cycle.
  wire [PQ_IRQ_W-1:0] irq_set = {i_zc.cur, i_zc.comb, i_zc.volt, i_zc.tmo,
      class_change}; // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05]
  wire [PQ_IRQ_W-1:0] irq_clr = wr_irq_sts ? i_reg.wdata[PQ_IRQ_W-1:0] : '0;
  assign irq_sts_d = (irq_sts_q & ~irq_clr) | irq_set;
  wire irq_pending = |(irq_sts_d & irq_en_q); // [RULE_21]

  // Falling edge of each energy pulse output latches the sign of that pulse.
  wire [3:0] pulse_fall = pulse_q & ~i_pulse_out;
  wire [3:0] neg_d = (pulse_fall & i_pulse_neg) | (~pulse_fall & neg_q); // [RULE_08]

  // Overcurrent compare on enabled channels only.
  logic [3:0] oc_hit;
  logic [2:0] sag_hit;
  logic [2:0] surge_hit;
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_oc
      assign oc_hit[p] = i_overcurrent_enable[p] && (i_irms[p] > oc_thr_q); // [RULE_11] [RULE_19]
    end
    for (p = 0; p < 3; p++) begin : g_volt
      assign sag_hit[p] = i_vrms[p] < sag_thr_q;
      assign surge_hit[p] = i_vrms[p] > surge_thr_q;
    end
  endgenerate

  // Event pin condition from every enabled source.
  wire [PQ_EVT_W-1:0] evt_src = {ready_q, class_idle, neg_d, surge_q, sag_q};
  wire evt_active = |(evt_src & evt_en_q); // [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_21]

  // Configuration registers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_en_q <= PQ_RST_IRQ_EN;
      evt_en_q <= PQ_RST_EVT_EN;
      oc_thr_q <= PQ_RST_OC_THR; // [RULE_10]
      o_voltage_ref_value <= PQ_RST_VREF; // [RULE_12]
      sag_thr_q <= PQ_RST_SAG_THR; // [RULE_13]
      surge_thr_q <= PQ_RST_SURGE_THR; // [RULE_15]
    end else begin
      if (wr_irq_en) begin
        irq_en_q <= i_reg.wdata[PQ_IRQ_W-1:0]; // [RULE_22]
      end
      if (wr_evt_en) begin
        evt_en_q <= i_reg.wdata[PQ_EVT_W-1:0]; // [RULE_22]
      end
      if (wr_oc_thr) begin
        oc_thr_q <= i_reg.wdata[PQ_VW-1:0]; // [RULE_10]
      end
      if (wr_vref) begin
        o_voltage_ref_value <= i_reg.wdata[PQ_VW-1:0]; // [RULE_12]
      end
      if (wr_sag_thr) begin
        sag_thr_q <= i_reg.wdata[PQ_VW-1:0]; // [RULE_13]
      end
      if (wr_surge_thr) begin
        surge_thr_q <= i_reg.wdata[PQ_VW-1:0]; // [RULE_15]
      end
    end
  end

  // Event tracking, interrupt status and pins.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_sts_q <= '0;
      idle_q <= '0;
      pulse_q <= '0;
      neg_q <= '0;
      ready_q <= 1'b0;
      o_irq_n <= 1'b1;
      o_event_n <= 1'b1;
    end else begin
      irq_sts_q <= irq_sts_d;
      idle_q <= i_idle; // [RULE_17]
      pulse_q <= i_pulse_out;
      neg_q <= neg_d;
      ready_q <= i_sample_ready; // [RULE_06]
      o_irq_n <= ~irq_pending; // [RULE_21]
      o_event_n <= ~evt_active; // [RULE_21]
    end
  end

  // Overcurrent flags and captures.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      oc_flag_q <= '0;
      oc_cap_q <= {4{PQ_RST_OC_CAP}};
    end else if (i_irms_upd) begin
      oc_flag_q <= oc_hit; // [RULE_20]
      for (int i = 0; i < 4; i++) begin
        if (oc_hit[i]) begin
          oc_cap_q[i] <= i_irms[i]; // [RULE_11]
        end
      end
    end
  end

  // Sag and surge state and captures.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sag_q <= '0;
      surge_q <= '0;
      sag_cap_q <= {3{PQ_RST_SAG_CAP}}; // [RULE_14]
      surge_cap_q <= {3{PQ_RST_SURGE_CAP}}; // [RULE_16]
    end else if (i_vrms_upd) begin
      sag_q <= sag_hit; // [RULE_18]
      surge_q <= surge_hit; // [RULE_18]
      for (int i = 0; i < 3; i++) begin
        if (sag_hit[i]) begin
          sag_cap_q[i] <= i_vrms[i]; // [RULE_14]
        end
        if (surge_hit[i]) begin
          surge_cap_q[i] <= i_vrms[i]; // [RULE_16]
        end
      end
    end
  end

  assign o_overcurrent_phase_flags = oc_flag_q;
  assign o_sag_state = sag_q;
  assign o_surge_state = surge_q;

  // Read multiplexer; unmapped addresses and reserved bits read as zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (i_reg.addr)
      PQ_ADDR_IRQ_EN: rd_mux = {16'h0000, irq_en_q};
      PQ_ADDR_IRQ_STS: rd_mux = {16'h0000, irq_sts_q};
      PQ_ADDR_EVT_EN: rd_mux = {15'h0000, evt_en_q};
      PQ_ADDR_OC_THR: rd_mux = {8'h00, oc_thr_q};
      PQ_ADDR_OC_CAP_A: rd_mux = {8'h00, oc_cap_q[0]};
      PQ_ADDR_OC_CAP_B: rd_mux = {8'h00, oc_cap_q[1]};
      PQ_ADDR_OC_CAP_C: rd_mux = {8'h00, oc_cap_q[2]};
      PQ_ADDR_OC_CAP_N: rd_mux = {8'h00, oc_cap_q[3]};
      PQ_ADDR_VREF: rd_mux = {8'h00, o_voltage_ref_value};
      PQ_ADDR_SAG_THR: rd_mux = {8'h00, sag_thr_q};
      PQ_ADDR_SAG_A: rd_mux = {8'h00, sag_cap_q[0]};
      PQ_ADDR_SAG_B: rd_mux = {8'h00, sag_cap_q[1]};
      PQ_ADDR_SAG_C: rd_mux = {8'h00, sag_cap_q[2]};
      PQ_ADDR_SURGE_THR: rd_mux = {8'h00, surge_thr_q};
      PQ_ADDR_SURGE_A: rd_mux = {8'h00, surge_cap_q[0]};
      PQ_ADDR_SURGE_B: rd_mux = {8'h00, surge_cap_q[1]};
      PQ_ADDR_SURGE_C: rd_mux = {8'h00, surge_cap_q[2]};
      PQ_ADDR_IDLE_STS: rd_mux = {14'h0000, idle_q}; // [RULE_17]
      PQ_ADDR_OC_STS: rd_mux = {28'h0000000, oc_flag_q}; // [RULE_20]
      default: rd_mux = 32'h00000000; // [RULE_22]
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 32'h00000000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_reg.rd;
      o_rd_data <= i_reg.rd ? rd_mux : 32'h00000000;
    end
  end

endmodule : pq_emc_top

// ==== test/pq_emc_properties.sv ====
`timescale 1ns/10ps
module pq_emc_checker
  import pq_emc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port.
  input wire pq_reg_req_t i_reg,
  input wire logic [31:0] o_rd_data,
  input wire logic o_rd_valid,
  // Rms inputs and status outputs.
  input wire logic i_irms_upd,
  input wire logic i_vrms_upd,
  input wire logic [3:0] i_overcurrent_enable,
  input wire logic o_irq_n,
  input wire logic o_event_n,
  input wire logic [3:0] o_overcurrent_phase_flags,
  input wire logic [2:0] o_surge_state,
  input wire logic [2:0] o_sag_state,
  input wire logic [PQ_VW-1:0] o_voltage_ref_value
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_single_rd;
    i_reg.rd ##1 !i_reg.rd;
  endsequence
  property p_rd_pulse;
    s_single_rd |-> o_rd_valid ##1 !o_rd_valid;
  endproperty
  property p_rst;
    disable iff (1'b0) !i_rst_n |=> o_irq_n && o_event_n && !o_rd_valid;
  endproperty
  property p_vref_rst;
    disable iff (1'b0) !i_rst_n |=> o_voltage_ref_value == PQ_RST_VREF;
  endproperty
  property p_rd_idle;
    !i_reg.rd |=> o_rd_data == 32'h0;
  endproperty
  property p_rd_unmapped;
    i_reg.rd && i_reg.addr == 12'h408 |=> o_rd_data == 32'h0;
  endproperty
  property p_vref_hold;
    !(i_reg.wr && i_reg.addr == PQ_ADDR_VREF) |=> $stable(o_voltage_ref_value);
  endproperty
  property p_irq_hold;
    !o_irq_n && !i_reg.wr && !$past(i_reg.wr) |=> !o_irq_n;
  endproperty
  property p_oc_off;
    i_irms_upd && !i_overcurrent_enable[0] |=> !o_overcurrent_phase_flags[0];
  endproperty
  property p_state_hold;
    !i_vrms_upd |=> $stable(o_sag_state) && $stable(o_surge_state);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid misplaced");
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  a_vref_rst: assert property (p_vref_rst) else $error("vref reset value");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
  a_vref_hold: assert property (p_vref_hold) else $error("vref changed");
  a_irq_hold: assert property (p_irq_hold) else $error("irq released");
  a_oc_off: assert property (p_oc_off) else $error("flag on disabled channel");
  a_state_hold: assert property (p_state_hold) else $error("state moved");
endmodule : pq_emc_checker

bind pq_emc_top pq_emc_checker pq_emc_checker_i (.i_clk, .i_rst_n, .i_reg, .o_rd_data,
  .o_rd_valid, .i_irms_upd, .i_vrms_upd, .i_overcurrent_enable, .o_irq_n, .o_event_n,
  .o_overcurrent_phase_flags, .o_surge_state, .o_sag_state, .o_voltage_ref_value);

// ==== test/pq_emc_meter.sv ====
`timescale 1ns/10ps
module pq_emc_meter
  import pq_emc_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Detector pulses and levels.
  output pq_zc_t o_zc,
  output logic [PQ_IDLE_W-1:0] o_idle,
  output logic o_sample_ready,
  output logic [3:0] o_pulse_out,
  output logic [3:0] o_pulse_neg
);
  initial begin
    o_zc = '0;
    o_idle = '0;
    o_sample_ready = 1'b0;
    o_pulse_out = 4'hF;
    o_pulse_neg = 4'h0;
  end
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick
  // Values 0 to 9 pulse one zero-crossing line, 10 pulses sample ready.
  task automatic strobe(input int b);
    tick();
    o_zc = pq_zc_t'(10'h1 << b);
    o_sample_ready = (b == 10);
    tick();
    o_zc = '0;
    o_sample_ready = 1'b0;
  endtask : strobe
  // Energy pulses idle high; the sign is valid at the falling edge.
  task automatic cf_pulse(input int k, input logic neg);
    tick();
    o_pulse_neg[k] = neg;
    o_pulse_out[k] = 1'b0;
    tick();
    o_pulse_out[k] = 1'b1;
  endtask : cf_pulse
  task automatic set_idle(input int b);
    tick();
    o_idle[b] = 1'b1;
  endtask : set_idle
endmodule : pq_emc_meter

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import pq_emc_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  pq_reg_req_t i_reg = '0;
  logic [3:0][PQ_VW-1:0] irms = '0;
  logic [2:0][PQ_VW-1:0] vrms = '0;
  logic irms_upd = 1'b0;
  logic vrms_upd = 1'b0;
  logic [3:0] oc_en = 4'h0;
  pq_zc_t zc;
  logic [PQ_IDLE_W-1:0] idle;
  logic rdy;
  logic [3:0] cf_out;
  logic [3:0] cf_neg;
  logic [31:0] rd_data;
  logic rd_valid;
  logic irq_n;
  logic event_n;
  logic [3:0] oc_flags;
  logic [2:0] surge;
  logic [2:0] sag;
  logic [PQ_VW-1:0] vref;
  int failures = 0;
  int tests_run = 0;
  pq_emc_meter pq_emc_meter_i (.i_clk(i_clk), .o_zc(zc), .o_idle(idle), .o_sample_ready(rdy),
    .o_pulse_out(cf_out), .o_pulse_neg(cf_neg));
  pq_emc_top pq_emc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg(i_reg),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_zc(zc), .i_idle(idle), .i_sample_ready(rdy),
    .i_pulse_out(cf_out), .i_pulse_neg(cf_neg), .i_irms(irms), .i_irms_upd(irms_upd),
    .i_vrms(vrms), .i_vrms_upd(vrms_upd), .i_overcurrent_enable(oc_en), .o_irq_n(irq_n),
    .o_event_n(event_n), .o_overcurrent_phase_flags(oc_flags), .o_surge_state(surge),
    .o_sag_state(sag), .o_voltage_ref_value(vref));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask : step
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    step();
    i_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step();
    i_reg.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    step();
    i_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    step();
    i_reg.rd = 1'b0;
    chk($sformatf("reg %h", a), e, rd_data);
    chk("read valid", 32'h1, {31'h0, rd_valid});
  endtask : rd
  task automatic t_regs();
    logic [11:0] a [12] = '{12'h406, 12'h407, 12'h409, 12'h40A, 12'h40F, 12'h410, 12'h411,
      12'h414, 12'h415, 12'h41F, 12'h48F, 12'h408};
    logic [31:0] e [12] = '{32'h0, 32'h0, 32'hFFFFFF, 32'h0, 32'h45D45, 32'h0, 32'h7FFFFF,
      32'hFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] m [7] = '{32'hFFFF, 32'h1FFFF, 32'hFFFFFF, 32'h0, 32'hFFFFFF, 32'hFFFFFF,
      32'h7FFFFF};
    for (int i = 0; i < 12; i++) rd(a[i], e[i]);
    for (int i = 0; i < 7; i++) begin
      wr(a[i], 32'hFFFFFFFF);
      rd(a[i], m[i]);
    end
    chk("vref", 32'hFFFFFF, {8'h0, vref});
    wr(PQ_ADDR_IRQ_EN, 32'h0);
    wr(PQ_ADDR_EVT_EN, 32'h0);
  endtask : t_regs
  task automatic t_irq();
    for (int b = 0; b < 16; b++) begin
      if (b < 6) pq_emc_meter_i.set_idle(b + 6);
      else pq_emc_meter_i.strobe(b - 6);
      repeat (2) step();
      chk("masked irq", 32'h1, {31'h0, irq_n});
      rd(PQ_ADDR_IRQ_STS, 32'h1 << b);
      wr(PQ_ADDR_IRQ_EN, 32'h1 << b);
      step();
      chk("irq", 32'h0, {31'h0, irq_n});
      wr(PQ_ADDR_IRQ_STS, 32'h1 << b);
      step();
      chk("cleared irq", 32'h1, {31'h0, irq_n});
      wr(PQ_ADDR_IRQ_EN, 32'h0);
    end
    rd(PQ_ADDR_IDLE_STS, 32'hFC0);
  endtask : t_irq
  task automatic t_rms();
    wr(PQ_ADDR_SAG_THR, 32'h100);
    wr(PQ_ADDR_SURGE_THR, 32'h200);
    wr(PQ_ADDR_OC_THR, 32'h100);
    wr(PQ_ADDR_EVT_EN, 32'h11);
    vrms = {24'h150, 24'h300, 24'h050};
    irms = {24'h050, 24'h200, 24'h080, 24'h300};
    oc_en = 4'hE;
    vrms_upd = 1'b1;
    irms_upd = 1'b1;
    step();
    vrms_upd = 1'b0;
    irms_upd = 1'b0;
    chk("sag", 32'h1, {29'h0, sag});
    chk("surge", 32'h2, {29'h0, surge});
    chk("oc flags", 32'h4, {28'h0, oc_flags});
    step();
    chk("sag event", 32'h0, {31'h0, event_n});
    rd(PQ_ADDR_SAG_A, 32'h50);
    rd(PQ_ADDR_SAG_B, 32'h7FFFFF);
    rd(PQ_ADDR_SURGE_B, 32'h300);
    rd(PQ_ADDR_OC_CAP_C, 32'h200);
    rd(PQ_ADDR_OC_CAP_A, 32'h0);
    rd(PQ_ADDR_OC_STS, 32'h4);
  endtask : t_rms
  task automatic t_event();
    for (int k = 0; k < 4; k++) begin
      wr(PQ_ADDR_EVT_EN, 32'h40 << k);
      pq_emc_meter_i.cf_pulse(k, 1'b1);
      step();
      chk("sign event", 32'h0, {31'h0, event_n});
      pq_emc_meter_i.cf_pulse(k, 1'b0);
      step();
      chk("sign clear", 32'h1, {31'h0, event_n});
    end
    wr(PQ_ADDR_EVT_EN, 32'h10000);
    pq_emc_meter_i.strobe(10);
    step();
    chk("ready event", 32'h0, {31'h0, event_n});
    step();
    chk("ready end", 32'h1, {31'h0, event_n});
    wr(PQ_ADDR_EVT_EN, 32'hFC00);
    step();
    chk("idle event", 32'h0, {31'h0, event_n});
  endtask : t_event
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    t_regs();
    t_irq();
    t_rms();
    t_event();
    results();
  end
endmodule : tb_top
